// >>> core/ctg_guard_if.sv
// ctg_guard_if: link between the register side and one guard timer
// assumes: all signals on the single system clock
`timescale 1ns/1ns
`default_nettype none
interface ctg_guard_if;
   import ctg_pkg::*;
   logic            tick;
   logic            enable;
   logic            raw;
   logic [GT_W-1:0] present_time;
   logic [GT_W-1:0] absent_time;
   logic            qualified;
   modport timer (input tick, enable, raw, present_time, absent_time, output qualified);
   modport ctrl  (output tick, enable, raw, present_time, absent_time, input qualified);
endinterface
`default_nettype wire

// >>> core/ctg_guard_timer.sv
// ctg_guard_timer: present/absent qualification of one raw tone detect
// assumes: raw already synchronised, tick is a one-cycle enable
`timescale 1ns/1ns
`default_nettype none
module ctg_guard_timer
   import ctg_pkg::*;
(
   // clock and reset
   input wire logic  clk,
   input wire logic  reset_n,
   // timer side of the link
   ctg_guard_if.timer gi
);
   ctg_gt_state_e   state_q;
   logic [GT_W-1:0] count_q;

   // ---------------------------------------------------------------
   // qualification state and up-counter
   // ---------------------------------------------------------------
   // count from zero on each edge, clear on a bounce
   always_ff @(posedge clk) begin
      if (!reset_n || !gi.enable) begin
         state_q <= GT_IDLE;
         count_q <= '0;
      end else begin
         case (state_q)
            GT_IDLE: begin
               count_q <= '0;
               if (gi.raw) state_q <= GT_PQUAL;
            end
            GT_PQUAL: begin
               if (!gi.raw) begin
                  state_q <= GT_IDLE;
                  count_q <= '0;
               end else if (count_q == gi.present_time) begin
                  state_q <= GT_PRES;
                  count_q <= '0;
               end else if (gi.tick) begin
                  count_q <= count_q + 1'b1;
               end
            end
            GT_PRES: begin
               count_q <= '0;
               if (!gi.raw) state_q <= GT_AQUAL;
            end
            GT_AQUAL: begin
               if (gi.raw) begin
                  state_q <= GT_PRES;
                  count_q <= '0;
               end else if (count_q == gi.absent_time) begin
                  state_q <= GT_IDLE;
                  count_q <= '0;
               end else if (gi.tick) begin
                  count_q <= count_q + 1'b1;
               end
            end
            default: begin
               state_q <= GT_IDLE;
               count_q <= '0;
            end
         endcase
      end
   end

   // qualified level, registered one cycle after the state register, gated by enable
   always_ff @(posedge clk) begin
      if (!reset_n) gi.qualified <= 1'b0;
      else gi.qualified <= gi.enable && (state_q == GT_PRES || state_q == GT_AQUAL);
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_gt_step;
      @(posedge clk) disable iff (!reset_n)
      (count_q != $past(count_q)) |-> (count_q == '0) ||
         (($past(gi.tick)) && (count_q == $past(count_q) + 1'b1));
   endproperty
   a_gt_step: assert property (p_gt_step) else $error("guard count moved off tick");

   property p_gt_bounce;
      @(posedge clk) disable iff (!reset_n)
      (state_q == GT_PQUAL && !gi.raw) |=> (state_q == GT_IDLE && count_q == '0);
   endproperty
   a_gt_bounce: assert property (p_gt_bounce) else $error("bounce did not clear timer");

   property p_gt_accept;
      @(posedge clk) disable iff (!reset_n)
      (state_q == GT_PQUAL && gi.raw && gi.enable && count_q == gi.present_time)
         ##1 gi.enable |=> gi.qualified;
   endproperty
   a_gt_accept: assert property (p_gt_accept) else $error("presence not accepted");

   property p_gt_end;
      @(posedge clk) disable iff (!reset_n)
      (state_q == GT_AQUAL && !gi.raw && gi.enable && count_q == gi.absent_time)
         |=> ##1 !gi.qualified;
   endproperty
   a_gt_end: assert property (p_gt_end) else $error("tone end not recognised");

   property p_gt_rerise;
      @(posedge clk) disable iff (!reset_n)
      (state_q == GT_AQUAL && gi.raw && gi.enable) |=> (state_q == GT_PRES && count_q == '0);
   endproperty
   a_gt_rerise: assert property (p_gt_rerise) else $error("rerise did not restart");
endmodule
`default_nettype wire

// >>> core/ctg_pkg.sv
// ctg_pkg: constants, register map and types of the caller-id guard block
// assumes: 250 MHz clock, AHB-Lite register access, one word per register
package ctg_pkg;
   // ---------------------------------------------------------------
   // clock and guard tick timing
   // ---------------------------------------------------------------
   localparam real CLK_PERIOD_NS  = 4.0;
   localparam real TICK_PERIOD_MS = 0.8582;
   localparam int  TICK_CYCLES_DFLT = int'(TICK_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int  TICK_CNT_W     = 18;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int GT_W   = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 8;
   localparam int PIN_W  = 19;
   // ---------------------------------------------------------------
   // register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_STATUS  = 8'hB1;
   localparam logic [IDX_W-1:0] IDX_FSK     = 8'hB4;
   localparam logic [IDX_W-1:0] IDX_DTMF    = 8'hB5;
   localparam logic [IDX_W-1:0] IDX_DPT     = 8'hB6;
   localparam logic [IDX_W-1:0] IDX_DAT     = 8'hB7;
   localparam logic [IDX_W-1:0] IDX_APT     = 8'hBE;
   localparam logic [IDX_W-1:0] IDX_AAT     = 8'hBF;
   localparam logic [IDX_W-1:0] IDX_CTRL    = 8'hC8;
   localparam logic [IDX_W-1:0] IDX_IFLAG   = 8'hCA;
   localparam logic [IDX_W-1:0] IDX_IMASK   = 8'hCB;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [GT_W-1:0] DPT_RST = 8'h19;
   localparam logic [GT_W-1:0] DAT_RST = 8'h19;
   localparam logic [GT_W-1:0] APT_RST = 8'h0F;
   localparam logic [GT_W-1:0] AAT_RST = 8'h0F;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_GLOBAL = 0;
   localparam int CTRL_FSK    = 1;
   localparam int CTRL_ALERT  = 2;
   localparam int CTRL_DTMF   = 3;
   localparam int CTRL_W      = 4;
   localparam int DR_AHIGH    = 7;
   localparam int DR_ALOW     = 6;
   localparam int DR_DHIGH    = 5;
   localparam int DR_DLOW     = 4;
   localparam int DR_KEY_W    = 4;
   localparam int ST_ALERT    = 1;
   localparam int ST_DTMF     = 3;
   localparam int EV_DTMF     = 0;
   localparam int EV_ALERT    = 1;
   localparam int EV_FSK      = 2;
   localparam int EV_W        = 3;
   // ---------------------------------------------------------------
   // guard timer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      GT_IDLE  = 2'b00,
      GT_PQUAL = 2'b01,
      GT_PRES  = 2'b11,
      GT_AQUAL = 2'b10
   } ctg_gt_state_e;
endpackage

// >>> core/ctg_top.sv
// ctg_top: caller-id receive enables, result registers, guard timing
// assumes: AHB-Lite single slave, detector pins asynchronous to clk
// Behaviour
// - global enable low turns all functions off
// - each function also needs its own enable
// - FSK register holds last received byte
// - DTMF key code in result bits 3..0
// - alert high tone bit 7, low bit 6
// - DTMF high group bit 5, low bit 4
// - guard timer steps once per 0.8582 ms tick
// - DTMF rise counts from zero, accept at match
// - DTMF drop during presence check clears timer
// - DTMF present time resets to 19H
// - DTMF fall counts, tone ends at match
// - DTMF absent time resets to 19H
// - alert rise qualified likewise, cleared on drop
// - alert fall qualified likewise, cleared on rise
// - alert present and absent reset to 0FH
// - DTMF ready set on data, cleared at end
// - qualified alert status follows guarded alert
// - DTMF ready rise sets sticky event flag
`timescale 1ns/1ns
`default_nettype none
module ctg_top
   import ctg_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [DATA_W-1:0] hwdata,
   input  wire logic              hready,
   output logic      [DATA_W-1:0] hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // detector pins
   input  wire logic              raw_dtmf_detect,
   input  wire logic              raw_alert_detect,
   input  wire logic [3:0]        dtmf_key_code_in,
   input  wire logic              dtmf_high_tone_in,
   input  wire logic              dtmf_low_tone_in,
   input  wire logic              alert_high_tone_in,
   input  wire logic              alert_low_tone_in,
   input  wire logic              fsk_byte_ready_in,
   input  wire logic [7:0]        fsk_byte_in,
   // detector enables
   output logic                   fsk_demod_enable,
   output logic                   alert_detect_enable,
   output logic                   dtmf_demod_enable,
   // status and interrupt
   output logic                   dtmf_ready_status,
   output logic                   qualified_alert_status,
   output logic                   irq
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [PIN_W-1:0]      sync1_q;
   logic [PIN_W-1:0]      sync2_q;
   logic [TICK_CNT_W-1:0] tick_cnt_q;
   logic                  tick_q;
   logic [CTRL_W-1:0]     ctrl_q;
   logic [GT_W-1:0]       dpt_q;
   logic [GT_W-1:0]       dat_q;
   logic [GT_W-1:0]       apt_q;
   logic [GT_W-1:0]       aat_q;
   logic [7:0]            fsk_rx_byte_q;
   logic [7:0]            dtmf_result_q;
   logic [EV_W-1:0]       flag_q;
   logic [EV_W-1:0]       mask_q;
   logic [EV_W-1:0]       event_d;
   logic                  fsk_rdy_q;
   logic                  wr_pend_q;
   logic [IDX_W-1:0]      wr_idx_q;
   logic                  acc;
   logic                  hit;
   logic [IDX_W-1:0]      idx;
   logic [DATA_W-1:0]     rd_mux;
   logic                  rd_clr;
   logic                  wr_now;
   logic                  s_dtmf;
   logic                  s_alert;
   logic [3:0]            s_key;
   logic                  s_dhigh;
   logic                  s_dlow;
   logic                  s_ahigh;
   logic                  s_alow;
   logic                  s_fsk_rdy;
   logic [7:0]            s_fsk;
   logic                  dtmf_rise;
   logic                  alert_rise;
   logic                  fsk_latch;

   ctg_guard_if gd ();
   ctg_guard_if ga ();

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // two stages, only the second stage is read
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {fsk_byte_in, fsk_byte_ready_in, alert_low_tone_in, alert_high_tone_in,
                     dtmf_low_tone_in, dtmf_high_tone_in, dtmf_key_code_in,
                     raw_alert_detect, raw_dtmf_detect};
         sync2_q <= sync1_q;
      end
   end

   // unpack synchronised pins
   assign s_dtmf    = sync2_q[0];
   assign s_alert   = sync2_q[1];
   assign s_key     = sync2_q[5:2];
   assign s_dhigh   = sync2_q[6];
   assign s_dlow    = sync2_q[7];
   assign s_ahigh   = sync2_q[8];
   assign s_alow    = sync2_q[9];
   assign s_fsk_rdy = sync2_q[10];
   assign s_fsk     = sync2_q[18:11];

   // ---------------------------------------------------------------
   // guard tick divider
   // ---------------------------------------------------------------
   // one-cycle tick every TICK_CYCLES clocks
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q     <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // detector enables
   // ---------------------------------------------------------------
   // individual enables gated by the global one
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fsk_demod_enable    <= 1'b0;
         alert_detect_enable <= 1'b0;
         dtmf_demod_enable   <= 1'b0;
      end else begin
         fsk_demod_enable    <= ctrl_q[CTRL_GLOBAL] & ctrl_q[CTRL_FSK];
         alert_detect_enable <= ctrl_q[CTRL_GLOBAL] & ctrl_q[CTRL_ALERT];
         dtmf_demod_enable   <= ctrl_q[CTRL_GLOBAL] & ctrl_q[CTRL_DTMF];
      end
   end

   // ---------------------------------------------------------------
   // guard timers
   // ---------------------------------------------------------------
   // dtmf and alert links
   assign gd.tick         = tick_q;
   assign gd.enable       = dtmf_demod_enable;
   assign gd.raw          = s_dtmf;
   assign gd.present_time = dpt_q;
   assign gd.absent_time  = dat_q;
   assign ga.tick         = tick_q;
   assign ga.enable       = alert_detect_enable;
   assign ga.raw          = s_alert;
   assign ga.present_time = apt_q;
   assign ga.absent_time  = aat_q;

   ctg_guard_timer u_dtmf_guard (
      .clk     (clk),
      .reset_n (reset_n),
      .gi      (gd.timer)
   );

   ctg_guard_timer u_alert_guard (
      .clk     (clk),
      .reset_n (reset_n),
      .gi      (ga.timer)
   );

   // qualified status levels and their rising edges
   assign dtmf_rise  = gd.qualified & ~dtmf_ready_status;
   assign alert_rise = ga.qualified & ~qualified_alert_status;
   assign fsk_latch  = s_fsk_rdy & ~fsk_rdy_q & fsk_demod_enable;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dtmf_ready_status      <= 1'b0;
         qualified_alert_status <= 1'b0;
         fsk_rdy_q              <= 1'b0;
      end else begin
         dtmf_ready_status      <= gd.qualified;
         qualified_alert_status <= ga.qualified;
         fsk_rdy_q              <= s_fsk_rdy;
      end
   end

   // ---------------------------------------------------------------
   // result registers
   // ---------------------------------------------------------------
   // last fsk byte, taken on the ready edge
   always_ff @(posedge clk) begin
      if (!reset_n) fsk_rx_byte_q <= '0;
      else if (fsk_latch) fsk_rx_byte_q <= s_fsk;
   end

   // tone group flags live, key code taken when ready rises
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dtmf_result_q <= '0;
      end else begin
         dtmf_result_q[DR_AHIGH] <= alert_detect_enable & s_ahigh;
         dtmf_result_q[DR_ALOW]  <= alert_detect_enable & s_alow;
         dtmf_result_q[DR_DHIGH] <= dtmf_demod_enable & s_dhigh;
         dtmf_result_q[DR_DLOW]  <= dtmf_demod_enable & s_dlow;
         if (dtmf_rise) dtmf_result_q[DR_KEY_W-1:0] <= s_key;
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   // address phase decode
   assign acc    = hsel & htrans[1] & hready;
   assign hit    = (haddr[31:10] == '0) && (haddr[1:0] == 2'b00);
   assign idx    = haddr[9:2];
   assign rd_clr = acc & ~hwrite & hit & (idx == IDX_IFLAG);
   assign wr_now = wr_pend_q & hready;

   // read mux, unmapped reads as zero
   always_comb begin
      rd_mux = '0;
      if (hit) begin
         case (idx)
            IDX_STATUS: begin
               rd_mux[ST_DTMF]  = dtmf_ready_status;
               rd_mux[ST_ALERT] = qualified_alert_status;
            end
            IDX_FSK:   rd_mux[7:0] = fsk_rx_byte_q;
            IDX_DTMF:  rd_mux[7:0] = dtmf_result_q;
            IDX_DPT:   rd_mux[GT_W-1:0] = dpt_q;
            IDX_DAT:   rd_mux[GT_W-1:0] = dat_q;
            IDX_APT:   rd_mux[GT_W-1:0] = apt_q;
            IDX_AAT:   rd_mux[GT_W-1:0] = aat_q;
            IDX_CTRL:  rd_mux[CTRL_W-1:0] = ctrl_q;
            IDX_IFLAG: rd_mux[EV_W-1:0] = flag_q;
            IDX_IMASK: rd_mux[EV_W-1:0] = mask_q;
            default:   rd_mux = '0;
         endcase
      end
   end

   // bus handshake, zero wait states, always OKAY
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_idx_q  <= '0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready) wr_pend_q <= acc & hwrite & hit;
         if (acc) wr_idx_q <= idx;
         if (acc & ~hwrite) hrdata <= rd_mux;
      end
   end

   // writable settings
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_q <= '0;
         dpt_q  <= DPT_RST;
         dat_q  <= DAT_RST;
         apt_q  <= APT_RST;
         aat_q  <= AAT_RST;
         mask_q <= '0;
      end else if (wr_now) begin
         case (wr_idx_q)
            IDX_CTRL:  ctrl_q <= hwdata[CTRL_W-1:0];
            IDX_DPT:   dpt_q  <= hwdata[GT_W-1:0];
            IDX_DAT:   dat_q  <= hwdata[GT_W-1:0];
            IDX_APT:   apt_q  <= hwdata[GT_W-1:0];
            IDX_AAT:   aat_q  <= hwdata[GT_W-1:0];
            IDX_IMASK: mask_q <= hwdata[EV_W-1:0];
            default:   mask_q <= mask_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // event flags and interrupt
   // ---------------------------------------------------------------
   // sticky flags, cleared by reading, a new event wins
   always_comb begin
      event_d           = '0;
      event_d[EV_DTMF]  = dtmf_rise;
      event_d[EV_ALERT] = alert_rise;
      event_d[EV_FSK]   = fsk_latch;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) flag_q <= '0;
      else flag_q <= (rd_clr ? '0 : flag_q) | event_d;
   end

   // level interrupt from unmasked flags
   always_ff @(posedge clk) begin
      if (!reset_n) irq <= 1'b0;
      else irq <= |(flag_q & mask_q);
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_global_off;
      @(posedge clk) disable iff (!reset_n)
      !ctrl_q[CTRL_GLOBAL] |=> !fsk_demod_enable && !alert_detect_enable && !dtmf_demod_enable;
   endproperty
   a_global_off: assert property (p_global_off) else $error("function on without global");

   property p_fsk_latch;
      @(posedge clk) disable iff (!reset_n)
      fsk_latch |=> fsk_rx_byte_q == $past(s_fsk);
   endproperty
   a_fsk_latch: assert property (p_fsk_latch) else $error("fsk byte not latched");

   property p_key_latch;
      @(posedge clk) disable iff (!reset_n)
      dtmf_rise |=> dtmf_result_q[DR_KEY_W-1:0] == $past(s_key) && dtmf_ready_status;
   endproperty
   a_key_latch: assert property (p_key_latch) else $error("key code not latched");

   property p_dtmf_flag;
      @(posedge clk) disable iff (!reset_n)
      $rose(dtmf_ready_status) && mask_q[EV_DTMF] |-> flag_q[EV_DTMF] ##1 irq;
   endproperty
   a_dtmf_flag: assert property (p_dtmf_flag) else $error("dtmf event flag missed");

   property p_alert_status;
      @(posedge clk) disable iff (!reset_n)
      !alert_detect_enable |=> ##1 !qualified_alert_status;
   endproperty
   a_alert_status: assert property (p_alert_status) else $error("alert status while off");
endmodule
`default_nettype wire

// >>> tb/ctg_bench.sv
// ctg_bench: register and guard-timing tests of ctg_top
// assumes: short tick of 4 clocks, zero-wait AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
module ctg_bench
   import ctg_pkg::*;
;
   logic clk, reset_n, hsel, hwrite, irq, hresp, hreadyout;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [3:0] key;
   logic rd_dt, ra, dh, dl, ah, al, fr, en_f, en_a, en_d, st_d, st_a;
   logic [7:0] fb;
   int n_mismatch, checks, cyc, i;
   ctg_line_model line (.clk(clk), .raw_dtmf(rd_dt), .raw_alert(ra), .key(key), .d_hi(dh),
      .d_lo(dl), .a_hi(ah), .a_lo(al), .f_rdy(fr), .f_byte(fb));
   ctg_top #(.TICK_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .raw_dtmf_detect(rd_dt),
      .raw_alert_detect(ra), .dtmf_key_code_in(key), .dtmf_high_tone_in(dh),
      .dtmf_low_tone_in(dl), .alert_high_tone_in(ah), .alert_low_tone_in(al),
      .fsk_byte_ready_in(fr), .fsk_byte_in(fb), .fsk_demod_enable(en_f),
      .alert_detect_enable(en_a), .dtmf_demod_enable(en_d), .dtmf_ready_status(st_d),
      .qualified_alert_status(st_a), .irq(irq));
   // --------------------------------------------------------
   // clock and cycle ceiling
   // --------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   // single AHB-Lite transfer, waits on hready in both phases
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'h0};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      {hsel, htrans} <= 3'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   // read and compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // --------------------------------------------------------
   // main sequence
   // --------------------------------------------------------
   initial begin
      {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {n_mismatch, checks, cyc} = '0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rchk(IDX_DPT, 32'h19);
      rchk(IDX_DAT, 32'h19);
      rchk(IDX_APT, 32'h0F);
      rchk(IDX_AAT, 32'h0F);
      rchk(8'h00, 32'h0);
      chk(hresp, 1'b0);
      bus(1'b1, IDX_CTRL, 32'h9);
      repeat (2) @(posedge clk);
      chk({en_f, en_a, en_d}, 3'b001);
      bus(1'b1, IDX_CTRL, 32'hE);
      repeat (2) @(posedge clk);
      chk({en_f, en_a, en_d}, 3'b000);
      bus(1'b1, IDX_CTRL, 32'hF);
      repeat (2) @(posedge clk);
      chk({en_f, en_a, en_d}, 3'b111);
      bus(1'b1, IDX_DPT, 32'h2);
      rchk(IDX_DPT, 32'h2);
      bus(1'b1, IDX_DAT, 32'h2);
      bus(1'b1, IDX_APT, 32'h1);
      bus(1'b1, IDX_IMASK, 32'h1);
      // glitch shorter than the present time is not accepted
      line.dtmf(1'b1, 4'h5);
      repeat (3) @(posedge clk);
      line.dtmf(1'b0, 4'h5);
      repeat (40) @(posedge clk);
      chk(st_d, 1'b0);
      // qualified key press, flag and interrupt
      line.dtmf(1'b1, 4'h5);
      for (i = 0; i < 100 && st_d !== 1'b1; i++) @(posedge clk);
      chk(st_d, 1'b1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      rchk(IDX_DTMF, 32'h35);
      rchk(IDX_STATUS, 32'h8);
      rchk(IDX_IFLAG, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      // short drop inside the absent time keeps the key press
      line.dtmf(1'b0, 4'h5);
      repeat (2) @(posedge clk);
      line.dtmf(1'b1, 4'h5);
      repeat (20) @(posedge clk);
      chk(st_d, 1'b1);
      line.dtmf(1'b0, 4'h5);
      for (i = 0; i < 100 && st_d !== 1'b0; i++) @(posedge clk);
      chk(st_d, 1'b0);
      // alert tone qualification and its result bits
      line.alert(1'b1);
      for (i = 0; i < 100 && st_a !== 1'b1; i++) @(posedge clk);
      chk(st_a, 1'b1);
      bus(1'b0, IDX_DTMF, 32'h0);
      chk(rd[7:4], 4'hC);
      line.alert(1'b0);
      for (i = 0; i < 100 && st_a !== 1'b0; i++) @(posedge clk);
      chk(st_a, 1'b0);
      line.fsk(8'hA5);
      repeat (6) @(posedge clk);
      rchk(IDX_FSK, 32'hA5);
      finish_test();
   end
endmodule
`default_nettype wire

// >>> tb/ctg_line_model.sv
// ctg_line_model: behavioural tone detectors and fsk demodulator
// assumes: bench calls its tasks right after a rising clk edge
`timescale 1ns/1ns
`default_nettype none
module ctg_line_model (
   // clock
   input  wire logic       clk,
   // detector pins
   output var  logic       raw_dtmf,
   output var  logic       raw_alert,
   output var  logic [3:0] key,
   output var  logic       d_hi,
   output var  logic       d_lo,
   output var  logic       a_hi,
   output var  logic       a_lo,
   output var  logic       f_rdy,
   output var  logic [7:0] f_byte
);
   // --------------------------------------------------------
   // idle line at time zero
   // --------------------------------------------------------
   initial begin
      {raw_dtmf, raw_alert, d_hi, d_lo, a_hi, a_lo, f_rdy} = '0;
      key    = 4'hA;
      f_byte = 8'h3C;
   end
   // dtmf tone on or off, key lines invert when no tone
   task automatic dtmf(input logic on, input logic [3:0] k);
      raw_dtmf <= on;
      {d_hi, d_lo} <= {on, on};
      key <= on ? k : ~k;
   endtask
   // alert dual tone on or off
   task automatic alert(input logic on);
      {raw_alert, a_hi, a_lo} <= {on, on, on};
   endtask
   // one received byte, strobe held long enough for the syncs
   task automatic fsk(input logic [7:0] b);
      f_byte <= b;
      f_rdy  <= 1'b1;
      repeat (6) @(posedge clk);
      f_rdy  <= 1'b0;
      f_byte <= ~b;
   endtask
endmodule
`default_nettype wire
